//--- hdl/cie_core.sv
// Interrupt entry/return sequencer with stack pointer and status register.
// Assumes the pipeline reports each completed instruction with insn_done,
// and that stack_rdata is valid one cycle after stack_re.
`timescale 1ns/10ps
`default_nettype none
`include "cie_map.svh"

// Functional notes
// RULE1 - ALU op on two registers in one cycle
// RULE2 - Take source only if own and global enabled
// RULE3 - Lowest vector number wins; reset above all
// RULE4 - Accepting an interrupt clears global enable
// RULE5 - Return from interrupt sets global enable
// RULE6 - Hardware clears the serviced flag on vectoring
// RULE7 - Writing one clears a flag, zero ignored
// RULE8 - Flag latches even while source disabled
// RULE9 - Pending flags served in priority order later
// RULE10 - Level sources request only while present
// RULE11 - One instruction runs after return first
// RULE12 - Status register never saved or restored
// RULE13 - Global-off instruction blocks same-cycle requests
// RULE14 - Instruction after global-on runs before service
// RULE15 - Entry takes four cycles, pushes return address
// RULE16 - Vector jump takes three cycles
// RULE17 - Multi-cycle instruction finishes before entry
// RULE18 - Wake from sleep adds four cycles
// RULE19 - Return takes four cycles, pops, adds two
// RULE20 - Ten-bit stack pointer, high byte zero-padded
// RULE21 - Status bit 6 is the bit-copy store
// RULE22 - Sign bit always negative xor overflow
// RULE23 - Status holds H V N Z C flags
// RULE24 - Address push subtracts two, byte push one
// RULE25 - Flag set beats same-cycle clear
module cie_core
    import cie_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Instruction pipeline
    input  wire logic       insn_done,
    input  wire cie_insn_type insn_kind,
    input  wire logic [15:0] ret_addr,
    input  wire cie_alu_op_type alu_op,
    input  wire logic [7:0] op_a,
    input  wire logic [7:0] op_b,
    input  wire logic       bit_in,
    input  wire logic       core_sleeping,
    output logic            pipe_hold,
    output logic            vector_go,
    output logic [2:0]      vector_num,
    output logic            handler_go,
    output logic            return_go,
    output logic [15:0]     return_pc,
    output logic [7:0]      alu_result,
    output logic            alu_result_we,
    output logic            t_bit,
    // Stack memory
    output logic            stack_we,
    output logic            stack_re,
    output logic [9:0]      stack_addr,
    output logic [7:0]      stack_wdata,
    input  wire logic [7:0] stack_rdata,
    // Interrupt sources
    input  wire logic [7:0] src_event,
    input  wire logic [7:0] src_level,
    output logic [7:0]      src_ack,
    // I/O register port
    input  wire logic [5:0] io_addr,
    input  wire logic       io_we,
    input  wire logic [7:0] io_wdata,
    output logic [7:0]      io_rdata,
    // State views
    output logic [7:0]      status_flags,
    output logic [9:0]      stack_ptr
);
    cie_state_type st_r;
    cie_state_type st_nxt;
    cie_alu_if     alu_bus ();

    logic [7:0] pend;
    logic [7:0] req;
    logic [2:0] win;
    logic       take;
    logic       accept;
    logic [7:0] clr_sw;
    logic [7:0] clr_hw;
    logic [7:0] set_hw;
    logic [7:0] rd_val;

    function automatic logic [2:0] first_set(input logic [7:0] r);
        logic [2:0] idx;
        idx = 3'd0;
        for (int i = 7; i >= 0; i--) begin
            if (r[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    cie_alu u_alu (
        .bus (alu_bus.alu)
    );

    assign alu_bus.op  = alu_op;
    assign alu_bus.a   = op_a;
    assign alu_bus.b   = op_b;
    assign alu_bus.cin = st_r.cpu_status_flags[`CIE_BIT_C];

    // Latched flags for edge sources, live condition for level sources
    assign pend = (st_r.flag & ~`CIE_LEVEL_MASK)
                | (src_level & `CIE_LEVEL_MASK);      // see RULE10
    assign req  = pend & st_r.en;                     // see RULE2
    assign win  = first_set(req);                     // see RULE3 see RULE9

    // Boundary check; a same-cycle global-off blocks acceptance
    assign take = insn_done && st_r.cpu_status_flags[`CIE_BIT_I] && (|req)
               && insn_kind != global_irq_off_insn  // see RULE13
               && insn_kind != return_from_irq_insn;  // see RULE17

    always_comb begin
        rd_val = 8'h00;
        case (io_addr)
            `CIE_ADDR_FLAG:    rd_val = st_r.flag;
            `CIE_ADDR_ENABLE:  rd_val = st_r.en;
            `CIE_ADDR_SP_LOW:  rd_val = st_r.sp[7:0];
            `CIE_ADDR_SP_HIGH: rd_val = {6'h00, st_r.sp[9:8]}; // see RULE20
            `CIE_ADDR_STATUS:  rd_val = st_r.cpu_status_flags;
            default:           rd_val = 8'h00;
        endcase
    end

    always_comb begin
        st_nxt        = st_r;
        accept        = 1'b0;
        clr_sw        = 8'h00;
        clr_hw        = 8'h00;
        set_hw        = src_event & ~`CIE_LEVEL_MASK;
        st_nxt.rdata  = rd_val;
        st_nxt.vec_go = 1'b0;
        st_nxt.hnd_go = 1'b0;
        st_nxt.ret_go = 1'b0;
        st_nxt.ack    = 8'h00;
        st_nxt.mem_we = 1'b0;
        st_nxt.mem_re = 1'b0;
        st_nxt.res_we = 1'b0;

        // Software register writes
        if (io_we) begin
            case (io_addr)
                `CIE_ADDR_FLAG:    clr_sw = io_wdata;  // see RULE7
                `CIE_ADDR_ENABLE:  st_nxt.en = io_wdata;
                `CIE_ADDR_SP_LOW:  st_nxt.sp[7:0] = io_wdata;
                `CIE_ADDR_SP_HIGH: st_nxt.sp[9:8] = io_wdata[1:0];
                `CIE_ADDR_STATUS:  st_nxt.cpu_status_flags = io_wdata;
                default: ;
            endcase
        end

        case (st_r.seq)
            seq_run: begin
                if (insn_done) begin
                    case (insn_kind)
                        alu_insn: begin
                            // Result written back at the end of this cycle
                            st_nxt.res    = alu_bus.res;  // see RULE1
                            st_nxt.res_we = 1'b1;
                            st_nxt.cpu_status_flags[`CIE_BIT_V] = alu_bus.v; // see RULE23
                            st_nxt.cpu_status_flags[`CIE_BIT_N] = alu_bus.n;
                            st_nxt.cpu_status_flags[`CIE_BIT_Z] = alu_bus.z;
                            if (alu_op != alu_and && alu_op != alu_or
                                && alu_op != alu_eor) begin
                                st_nxt.cpu_status_flags[`CIE_BIT_H] = alu_bus.h;
                                st_nxt.cpu_status_flags[`CIE_BIT_C] = alu_bus.c;
                            end
                        end
                        bit_store_insn: begin
                            st_nxt.cpu_status_flags[`CIE_BIT_T] = bit_in; // see RULE21
                        end
                        global_irq_on_insn: begin
                            // Takes effect for the next boundary only
                            st_nxt.cpu_status_flags[`CIE_BIT_I] = 1'b1;   // see RULE14
                        end
                        global_irq_off_insn: begin
                            st_nxt.cpu_status_flags[`CIE_BIT_I] = 1'b0;   // see RULE13
                        end
                        push_insn: st_nxt.sp = st_r.sp - `CIE_SP_BYTE;
                        pop_insn:  st_nxt.sp = st_r.sp + `CIE_SP_BYTE;
                        call_insn: st_nxt.sp = st_r.sp - `CIE_SP_ADDR; // see RULE24
                        ret_insn:  st_nxt.sp = st_r.sp + `CIE_SP_ADDR;
                        return_from_irq_insn: begin
                            st_nxt.seq = seq_return;
                            st_nxt.cnt = 3'd0;
                        end
                        default: ;
                    endcase
                    accept = take;
                end else if (core_sleeping && st_r.cpu_status_flags[`CIE_BIT_I]
                             && (|req)) begin
                    st_nxt.seq = seq_wake;                     // see RULE18
                    st_nxt.cnt = 3'd0;
                end
            end
            seq_wake: begin
                if (st_r.cnt == `CIE_WAKE_LAST) begin
                    // A level request may have gone away meanwhile
                    accept     = |req;
                    st_nxt.seq = seq_run;
                end else begin
                    st_nxt.cnt = st_r.cnt + 3'd1;
                end
            end
            seq_entry: begin
                // Return address pushed, low byte first
                if (st_r.cnt == 3'd0) begin
                    st_nxt.mem_we = 1'b1;                      // see RULE15
                    st_nxt.maddr  = st_r.sp;
                    st_nxt.mwdata = st_r.pc[7:0];
                end else if (st_r.cnt == 3'd1) begin
                    st_nxt.mem_we = 1'b1;
                    st_nxt.maddr  = st_r.sp - `CIE_SP_BYTE;
                    st_nxt.mwdata = st_r.pc[15:8];
                    st_nxt.sp     = st_r.sp - `CIE_SP_ADDR;   // see RULE24
                end
                if (st_r.cnt == `CIE_ENTRY_LAST) begin
                    st_nxt.vec_go = 1'b1;
                    st_nxt.seq    = seq_vjmp;
                    st_nxt.cnt    = 3'd0;
                end else begin
                    st_nxt.cnt = st_r.cnt + 3'd1;
                end
            end
            seq_vjmp: begin
                if (st_r.cnt == `CIE_JUMP_LAST) begin
                    st_nxt.hnd_go = 1'b1;                      // see RULE16
                    st_nxt.seq    = seq_run;
                end else begin
                    st_nxt.cnt = st_r.cnt + 3'd1;
                end
            end
            seq_return: begin
                // Pop high byte then low byte; status not restored, only bit I set at the end
                if (st_r.cnt == 3'd0) begin
                    st_nxt.mem_re = 1'b1;                      // see RULE19
                    st_nxt.maddr  = st_r.sp + `CIE_SP_BYTE;
                end else if (st_r.cnt == 3'd1) begin
                    st_nxt.mem_re = 1'b1;
                    st_nxt.maddr  = st_r.sp + `CIE_SP_ADDR;
                end else if (st_r.cnt == 3'd2) begin
                    // Read data arrives one cycle after each strobe
                    st_nxt.pc[15:8] = stack_rdata;
                end else begin
                    st_nxt.pc[7:0] = stack_rdata;
                end
                if (st_r.cnt == `CIE_RETURN_LAST) begin
                    st_nxt.sp     = st_r.sp + `CIE_SP_ADDR;   // see RULE19
                    st_nxt.cpu_status_flags[`CIE_BIT_I] = 1'b1;           // see RULE5
                    st_nxt.ret_go = 1'b1;
                    // Next acceptance waits for the next insn_done
                    st_nxt.seq    = seq_run;                   // see RULE11
                end else begin
                    st_nxt.cnt = st_r.cnt + 3'd1;
                end
            end
            default: st_nxt.seq = seq_run;
        endcase

        // Entry: no copy of the status register is pushed
        if (accept) begin
            st_nxt.seq = seq_entry;                            // see RULE12
            st_nxt.cnt = 3'd0;
            st_nxt.vec = win;
            st_nxt.pc  = ret_addr;
            st_nxt.ack = 8'h01 << win;
            st_nxt.cpu_status_flags[`CIE_BIT_I] = 1'b0;                   // see RULE4
            clr_hw = (8'h01 << win) & ~`CIE_LEVEL_MASK;       // see RULE6
        end

        // Set wins over either clear; disabled flags still latch
        st_nxt.flag = (st_r.flag & ~(clr_sw | clr_hw)) | set_hw; // see RULE25
        st_nxt.flag = st_nxt.flag & ~`CIE_LEVEL_MASK;         // see RULE8
        st_nxt.cpu_status_flags[`CIE_BIT_S] = st_nxt.cpu_status_flags[`CIE_BIT_N]
                                ^ st_nxt.cpu_status_flags[`CIE_BIT_V];    // see RULE22
        st_nxt.stall = (st_nxt.seq != seq_run);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r      <= '0;
            st_r.seq  <= seq_run;
            st_r.sp   <= `CIE_TOP_OF_DATA_MEMORY;             // see RULE20
            st_r.cpu_status_flags <= `CIE_STATUS_RESET;
            st_r.en   <= `CIE_ENABLE_RESET;
            st_r.flag <= `CIE_FLAG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pipe_hold     = st_r.stall;
    assign vector_go     = st_r.vec_go;
    assign vector_num    = st_r.vec;
    assign handler_go    = st_r.hnd_go;
    assign return_go     = st_r.ret_go;
    assign return_pc     = st_r.pc;
    assign alu_result    = st_r.res;
    assign alu_result_we = st_r.res_we;
    assign t_bit         = st_r.cpu_status_flags[`CIE_BIT_T];             // see RULE21
    assign stack_we      = st_r.mem_we;
    assign stack_re      = st_r.mem_re;
    assign stack_addr    = st_r.maddr;
    assign stack_wdata   = st_r.mwdata;
    assign src_ack       = st_r.ack;
    assign io_rdata      = st_r.rdata;
    assign status_flags  = st_r.cpu_status_flags;
    assign stack_ptr     = st_r.sp;

    cli_block_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE13
        (insn_done && insn_kind == global_irq_off_insn
         && st_r.seq == seq_run) |=> (st_r.ack == 8'h00))
        else $error("interrupt accepted after global-off instruction");

    gie_needed_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
        (st_r.ack != 8'h00) |-> $past(st_r.cpu_status_flags[`CIE_BIT_I]))
        else $error("interrupt accepted with global enable clear");

    gie_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE4
        (st_r.ack != 8'h00) |-> !st_r.cpu_status_flags[`CIE_BIT_I])
        else $error("global enable not cleared on entry");

    entry_len_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE15
        (st_r.ack != 8'h00) |-> (!st_r.vec_go) [*4] ##1 st_r.vec_go)
        else $error("entry did not take four cycles");

    sp_entry_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE24
        (st_r.ack != 8'h00 && !io_we) ##1 (!io_we) [*3] |->
        (st_r.sp == $past(st_r.sp, 3) - `CIE_SP_ADDR))
        else $error("entry did not lower stack pointer by two");

    jump_len_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
        st_r.vec_go |-> ##3 st_r.hnd_go)
        else $error("vector jump did not take three cycles");

    ret_len_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE19
        (st_r.seq == seq_run && insn_done
         && insn_kind == return_from_irq_insn)
        |-> ##5 (st_r.ret_go && st_r.cpu_status_flags[`CIE_BIT_I]))
        else $error("return did not finish in four cycles with enable set");

    sign_bit_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE22
        st_r.cpu_status_flags[`CIE_BIT_S] ==
        (st_r.cpu_status_flags[`CIE_BIT_N] ^ st_r.cpu_status_flags[`CIE_BIT_V]))
        else $error("sign bit differs from negative xor overflow");

    set_wins_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE25
        (src_event[0] && io_we && io_addr == `CIE_ADDR_FLAG && io_wdata[0])
        |=> st_r.flag[0])
        else $error("flag event lost against a clear");
endmodule
`default_nettype wire

//--- hdl/cie_map.svh
// Address, field and timing constants of the interrupt entry block.
// Assumes a 200 MHz core clock; all counts are in core clock cycles.
`ifndef CIE_MAP_SVH
`define CIE_MAP_SVH

// I/O register addresses (6-bit direct I/O space)
`define CIE_ADDR_FLAG      6'h1c
`define CIE_ADDR_ENABLE    6'h1d
`define CIE_ADDR_SP_LOW    6'h3d
`define CIE_ADDR_SP_HIGH   6'h3e
`define CIE_ADDR_STATUS    6'h3f

// Status register bit positions
`define CIE_BIT_I          7
`define CIE_BIT_T          6
`define CIE_BIT_H          5
`define CIE_BIT_S          4
`define CIE_BIT_V          3
`define CIE_BIT_N          2
`define CIE_BIT_Z          1
`define CIE_BIT_C          0

// Source classes: set bits are level-type sources, no latched flag
`define CIE_LEVEL_MASK     8'hc0

// Reset values
`define CIE_TOP_OF_DATA_MEMORY 10'h2ff
`define CIE_STATUS_RESET   8'h00
`define CIE_ENABLE_RESET   8'h00
`define CIE_FLAG_RESET     8'h00

// Sequence lengths in clock cycles, last counter value of each phase
`define CIE_ENTRY_CYCLES   3'd4
`define CIE_ENTRY_LAST     3'd3
`define CIE_WAKE_LAST      3'd3
`define CIE_JUMP_LAST      3'd2
`define CIE_RETURN_LAST    3'd3

// Stack pointer steps
`define CIE_SP_BYTE        10'd1
`define CIE_SP_ADDR        10'd2

`endif

//--- hdl/cie_pkg.sv
// Types shared by the interrupt entry block and its arithmetic unit.
// Assumes nothing beyond a SystemVerilog compiler.
package cie_pkg;

    typedef enum logic [2:0] {
        seq_run,
        seq_wake,
        seq_entry,
        seq_vjmp,
        seq_return
    } cie_seq_type;

    typedef enum logic [3:0] {
        other_insn,
        alu_insn,
        global_irq_on_insn,
        global_irq_off_insn,
        return_from_irq_insn,
        bit_store_insn,
        bit_load_insn,
        push_insn,
        pop_insn,
        call_insn,
        ret_insn
    } cie_insn_type;

    typedef enum logic [2:0] {
        alu_add,
        alu_adc,
        alu_sub,
        alu_sbc,
        alu_and,
        alu_or,
        alu_eor
    } cie_alu_op_type;

    typedef struct packed {
        cie_seq_type seq;
        logic [2:0]  cnt;
        logic [2:0]  vec;
        logic [7:0]  flag;
        logic [7:0]  en;
        logic [9:0]  sp;
        logic [7:0]  cpu_status_flags;
        logic [15:0] pc;
        logic [7:0]  res;
        logic        res_we;
        logic [7:0]  rdata;
        logic        stall;
        logic        vec_go;
        logic        hnd_go;
        logic        ret_go;
        logic [7:0]  ack;
        logic        mem_we;
        logic        mem_re;
        logic [9:0]  maddr;
        logic [7:0]  mwdata;
    } cie_state_type;

endpackage

//--- hdl/cie_alu_if.sv
// Operand and result bundle between the core sequencer and its ALU.
// Assumes both ends sit in the same clock domain; purely combinational.
`timescale 1ns/10ps
`default_nettype none
interface cie_alu_if;
    import cie_pkg::*;
    cie_alu_op_type op;
    logic [7:0]     a;
    logic [7:0]     b;
    logic           cin;
    logic [7:0]     res;
    logic           h;
    logic           v;
    logic           n;
    logic           z;
    logic           c;

    modport core (output op, a, b, cin, input res, h, v, n, z, c);
    modport alu  (input op, a, b, cin, output res, h, v, n, z, c);
endinterface
`default_nettype wire

//--- hdl/cie_alu.sv
// Combinational 8-bit ALU producing result and arithmetic flags.
// Assumes the caller registers the result in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module cie_alu
    import cie_pkg::*;
(
    // Operands and results
    cie_alu_if.alu bus
);
    logic [8:0] wide;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;

    assign a = bus.a;
    assign b = bus.b;

    always_comb begin
        wide  = 9'h000;
        bus.h = 1'b0;
        bus.v = 1'b0;
        case (bus.op)
            alu_add, alu_adc: begin
                wide = {1'b0, a} + {1'b0, b}
                     + {8'h00, bus.op == alu_adc && bus.cin};
            end
            alu_sub, alu_sbc: begin
                wide = {1'b0, a} - {1'b0, b}
                     - {8'h00, bus.op == alu_sbc && bus.cin};
            end
            alu_and: wide = {1'b0, a & b};
            alu_or:  wide = {1'b0, a | b};
            alu_eor: wide = {1'b0, a ^ b};
            default: wide = 9'h000;
        endcase
        r = wide[7:0];
        case (bus.op)
            alu_add, alu_adc: begin
                bus.h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
                bus.v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
            end
            alu_sub, alu_sbc: begin
                bus.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
                bus.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
            end
            default: begin
                bus.h = 1'b0;
                bus.v = 1'b0;
            end
        endcase
        bus.res = r;
        bus.c   = wide[8];
        bus.n   = r[7];
        bus.z   = (r == 8'h00);
    end
endmodule
`default_nettype wire

//--- dv/cie_stack_model.sv
// Stack memory model standing behind the core's stack port.
// Assumes read data is wanted one cycle after a read strobe.
`timescale 1ns/10ps
`default_nettype none
module cie_stack_model (
    // Clock
    input  wire logic       clk,
    // Stack port
    input  wire logic       we,
    input  wire logic       re,
    input  wire logic [9:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata
);
    logic [7:0] mem [0:1023];
    initial rdata = 8'h5a;
    always @(posedge clk) begin
        if (we) mem[addr] <= wdata;
        // Stale data inverts each idle cycle, so a read one cycle late never matches by luck
        rdata <= re ? mem[addr] : ~rdata;
    end
endmodule
`default_nettype wire

//--- dv/cpu_interrupt_entry_and_status_tb.sv
// Self-checking bench for the interrupt entry and status core.
// Assumes the stack model answers reads one cycle late.
`timescale 1ns/10ps
`default_nettype none
`include "cie_map.svh"
module cpu_interrupt_entry_and_status_tb
    import cie_pkg::*;
;
    logic clk, sys_rst, insn_done, bit_in, sleeping, io_we;
    cie_insn_type insn_kind;
    cie_alu_op_type alu_op;
    logic [15:0] ret_addr, ra, sr;
    logic [7:0] op_a, op_b, src_event, src_level, io_wdata, rdata;
    logic [5:0] io_addr;
    wire logic ph, vg, hg, rg, awe, tb_t, swe, sre;
    wire logic [2:0] vn;
    wire logic [15:0] rpc;
    wire logic [7:0] ares, swd, ack, io_rdata, sf;
    wire logic [9:0] sad, sp;
    logic [2:0] expq [$];
    int err_count, n_compared, seed, k;

    cie_core dut_u (.clk(clk), .sys_rst(sys_rst), .insn_done(insn_done),
        .insn_kind(insn_kind), .ret_addr(ret_addr), .alu_op(alu_op),
        .op_a(op_a), .op_b(op_b), .bit_in(bit_in),
        .core_sleeping(sleeping), .pipe_hold(ph), .vector_go(vg),
        .vector_num(vn), .handler_go(hg), .return_go(rg),
        .return_pc(rpc), .alu_result(ares), .alu_result_we(awe),
        .t_bit(tb_t), .stack_we(swe), .stack_re(sre), .stack_addr(sad),
        .stack_wdata(swd), .stack_rdata(rdata), .src_event(src_event),
        .src_level(src_level), .src_ack(ack), .io_addr(io_addr),
        .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .status_flags(sf), .stack_ptr(sp));
    cie_stack_model mem_u (.clk(clk), .we(swe), .re(sre), .addr(sad),
        .wdata(swd), .rdata(rdata));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk) begin io_we <= 1'b1; io_addr <= a; io_wdata <= d; end
        @(posedge clk) io_we <= 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk) io_addr <= a;
        @(posedge clk) #1 chk(16'(io_rdata), 16'(e));
    endtask
    task insn(input cie_insn_type kd);
        ra = 16'($random(seed));
        @(posedge clk) begin insn_done <= 1'b1; insn_kind <= kd; end
        ret_addr <= ra;
        @(posedge clk) insn_done <= 1'b0;
    endtask
    // Counts edges until the selected pulse shows, then checks the count
    task wait_go(input int sel, input int e);
        for (k = 1; k < 20; k++) begin
            @(posedge clk) #1;
            if ((sel == 0 && vg === 1'b1) || (sel == 1 && hg === 1'b1) ||
                (sel == 2 && rg === 1'b1)) break;
        end
        chk(16'(k), 16'(e));
    endtask
    task irq(input logic [2:0] v);
        expq.push_back(v);
        insn(other_insn);
        wait_go(0, 4);
        wait_go(1, 3);
        chk(16'(sf[7]), 16'h0000);
    endtask
    task summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        if (vg === 1'b1) begin
            if (expq.size() == 0) chk(16'hffff, 16'(vn));
            else chk(16'(vn), 16'(expq.pop_front()));
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    initial begin
        seed = 79819;
        {sys_rst, insn_done, bit_in, sleeping, io_we} = 5'b10000;
        {ret_addr, op_a, op_b, src_event, io_wdata, io_addr} = '0;
        src_level = 8'h00;
        insn_kind = other_insn;
        alu_op = alu_add;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`CIE_ADDR_SP_LOW, 8'hff);
        rd(`CIE_ADDR_SP_HIGH, 8'h02);
        wr(`CIE_ADDR_SP_HIGH, 8'hff);
        rd(`CIE_ADDR_SP_HIGH, 8'h03);
        wr(`CIE_ADDR_SP_HIGH, 8'h02);
        $display("stack pointer test done");
        @(posedge clk) src_event <= 8'h0b;
        @(posedge clk) src_event <= 8'h00;
        rd(`CIE_ADDR_FLAG, 8'h0b);
        @(posedge clk) begin
            src_event <= 8'h01;
            io_we <= 1'b1;
            io_addr <= `CIE_ADDR_FLAG;
            io_wdata <= 8'h01;
        end
        @(posedge clk) begin
            src_event <= 8'h00;
            io_we <= 1'b0;
        end
        rd(`CIE_ADDR_FLAG, 8'h0b);
        wr(`CIE_ADDR_FLAG, 8'h01);
        rd(`CIE_ADDR_FLAG, 8'h0a);
        wr(`CIE_ADDR_ENABLE, 8'h3f);
        wr(`CIE_ADDR_STATUS, 8'h80);
        insn(global_irq_off_insn);
        repeat (2) @(posedge clk) #1;
        chk(16'(ph), 16'h0000);
        rd(`CIE_ADDR_STATUS, 8'h00);
        insn(global_irq_on_insn);
        @(posedge clk) #1 chk(16'(ph), 16'h0000);
        irq(3'd1);
        chk(16'(sp), 16'h02fd);
        rd(`CIE_ADDR_FLAG, 8'h08);
        $display("entry test done");
        sr = ra;
        insn(return_from_irq_insn);
        wait_go(2, 4);
        chk(rpc, sr);
        chk(16'(sp), 16'h02ff);
        chk(16'(sf[7]), 16'h0001);
        irq(3'd3);
        rd(`CIE_ADDR_FLAG, 8'h00);
        $display("return test done");
        repeat (4) begin
            @(posedge clk) begin
                op_a <= 8'($random(seed));
                op_b <= 8'($random(seed));
                bit_in <= 1'($random(seed));
            end
            insn(alu_insn);
            #1 chk(16'(awe), 16'h0001);
            chk(16'(ares), 16'(8'(op_a + op_b)));
            chk(16'(sf[4]), 16'(sf[2] ^ sf[3]));
        end
        insn(bit_store_insn);
        #1 chk(16'(tb_t), 16'(bit_in));
        $display("alu test done");
        @(posedge clk) src_level <= 8'h40;
        wr(`CIE_ADDR_ENABLE, 8'hff);
        @(posedge clk) src_level <= 8'h00;
        wr(`CIE_ADDR_STATUS, 8'h80);
        insn(other_insn);
        @(posedge clk) #1 chk(16'(ph), 16'h0000);
        @(posedge clk) begin
            src_level <= 8'h40;
            sleeping <= 1'b1;
        end
        expq.push_back(3'd6);
        wait_go(0, 9);
        wait_go(1, 3);
        @(posedge clk) begin
            sleeping <= 1'b0;
            src_level <= 8'h00;
        end
        $display("level and wake test done");
        summarize();
    end
endmodule
`default_nettype wire
